// ### inc/mpr_pkg.sv
// constants, types and state layout shared by the readout logic
package mpr_pkg;

	// mode register fields, positions on the address pins
	localparam int MR_W = 14;
	localparam int MR_COUNT = 7;
	localparam logic [MR_W-1:0] MR_RESET = 14'h0000;
	localparam int MR3_PAGE_LSB = 0;
	localparam int MR3_MPR_EN_BIT = 2;
	localparam int MR3_TEMP_EN_BIT = 5;
	localparam int MR3_FMT_LSB = 11;
	localparam int MR0_BL_LSB = 0;
	localparam int MR1_AL_LSB = 3;
	localparam int MR4_PRE_BIT = 11;
	localparam int MR5_CAPL_LSB = 0;
	localparam int A_START_BIT = 2;
	localparam int MR0_IDX = 0;
	localparam int MR1_IDX = 1;
	localparam int MR2_IDX = 2;
	localparam int MR3_IDX = 3;
	localparam int MR4_IDX = 4;
	localparam int MR5_IDX = 5;
	localparam int MR6_IDX = 6;

	// latency: cas latency code plus this base
	localparam logic [5:0] CL_BASE = 6'h09;

	// page 0 training patterns after power-up
	localparam logic [7:0] PAGE0_LOC0_RESET = 8'h55;
	localparam logic [7:0] PAGE0_LOC1_RESET = 8'h33;
	localparam logic [7:0] PAGE0_LOC2_RESET = 8'h0F;
	localparam logic [7:0] PAGE0_LOC3_RESET = 8'h00;

	// temperature status may be at most this old when read
	localparam int TEMP_MAX_AGE_MS = 32;
	localparam int CLK_FREQ_HZ = 100_000_000;
	localparam int TEMP_UPDATE_CYCLES = TEMP_MAX_AGE_MS * (CLK_FREQ_HZ / 1000);
	localparam int TEMP_CNT_W = 22;

	localparam logic [3:0] BEATS_BL8 = 4'h8;
	localparam logic [3:0] BEATS_BC4 = 4'h4;

	typedef enum logic [1:0] {
		FMT_SERIAL = 2'b00,
		FMT_PARALLEL = 2'b01,
		FMT_STAGGERED = 2'b10,
		FMT_RESERVED = 2'b11
	} fmt_e;

	typedef enum logic [1:0] {
		RATE_SUB1X = 2'b00,
		RATE_1X = 2'b01,
		RATE_2X = 2'b10,
		RATE_RESERVED = 2'b11
	} rate_e;

	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_WAIT = 2'b01,
		PH_PRE = 2'b10,
		PH_DATA = 2'b11
	} phase_e;

	typedef struct packed {
		logic csN;
		logic actN;
		logic rasN;
		logic casN;
		logic weN;
		logic bg;
		logic [1:0] ba;
		logic [MR_W-1:0] addr;
	} cmd_s;

	typedef struct packed {
		logic ckPrev;
		logic [MR_COUNT-1:0][MR_W-1:0] mr;
		logic [3:0][7:0] page0;
		logic [1:0] temp;
		logic [TEMP_CNT_W-1:0] tempCnt;
		phase_e phase;
		logic [5:0] cnt;
		logic [1:0] preCnt;
		logic [3:0] beatsLeft;
		logic [7:0] dataByte;
		logic par;
		logic [7:0] dq;
		logic dqOe;
		logic dqs;
		logic dqsOe;
		logic dbiN;
	} state_s;

endpackage

// ### hdl/sync2.sv
// two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module sync2 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_s;

	sync_s q;
	sync_s d;

	always_comb begin
		d.s1 = din;
		d.s2 = q.s1;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign dout = q.s2;

endmodule

// ### hdl/mpr_readout.sv
// multipurpose readout register mode: command capture and serial or parallel readout
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// What the document requires of this block and its controller
// [RULE1] with temperature enable set, page 2 status stays under 32 ms old
// [RULE2] with temperature enable clear, page 2 temperature bits freeze
// [RULE3] status codes: 00 sub 1x, 01 1x, 10 2x refresh, 11 reserved
// [RULE4] page 1 location 3 bits 2:0 mirror the latest parity latency setting
// [RULE5] readout uses fixed BL8 or BC4 only, never on-the-fly selection
// [RULE6] readout data is never inverted, read inversion enable is ignored
// [RULE7] controller starts BC4 readouts only at column 000 or 100
// [RULE8] page 0 resets to defaults, is writable, keeps writes until reset
// [RULE9] controller spaces page 1 to 3 reads by the long column delay
// [RULE10] controller precharges, waits, sets readout bit, waits mode delays
// [RULE11] format field selects serial, parallel, staggered or reserved; the code sends staggered and reserved as serial
// [RULE12] page field codes 00 to 11 pick pages 0 to 3
// [RULE13] reads in readout mode go to location picked by bank bits
// [RULE14] controller drives burst-chop pin high for BL8 when mode allows it
// [RULE15] BL8 returns beats 0 to 7; BL8 with start bit high is refused
// [RULE16] BC4 with start bit high returns beats 4 to 7
// [RULE17] low column bits are zero; other address bits are ignored
// [RULE18] data starts additive plus cas latency cycles after the command
// [RULE19] controller waits readout exit recovery time before clearing enable
// [RULE20] controller uses serial format for register and status pages
// [RULE21] strobes toggle with readout data, with programmed preamble length
// [RULE22] serial format puts one bit per beat, bit 7 first, on every lane
module mpr_readout
	import mpr_pkg::*;
#(
	parameter int TEMP_UPDATE = TEMP_UPDATE_CYCLES
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ck,
	input wire cmd_s cmdPins,
	input wire logic [1:0] tempRate,
	output logic [7:0] dqOut,
	output logic dqOe,
	output logic dqsOut,
	output logic dqsOe,
	output logic dbiNOut,
	output logic readoutActive
);

	localparam int SYNC_W = $bits(cmd_s) + 3;
	localparam logic [TEMP_CNT_W-1:0] TEMP_RELOAD =
		TEMP_CNT_W'(TEMP_UPDATE - 1);

	state_s q;
	state_s d;
	logic [SYNC_W-1:0] syncIn;
	logic [SYNC_W-1:0] syncOut;
	cmd_s cmd;
	logic ckS;
	logic [1:0] tempS;
	logic ckRise;
	logic ckFall;
	logic isMrs;
	logic isRd;
	logic isWr;
	logic mprOn;
	logic tempEn;
	logic bl8;
	logic refused;
	logic rdGo;
	logic wrHit;
	logic [5:0] rlLoad;
	logic [1:0] preLen;
	logic [7:0] locData;
	logic [2:0] mrSel;

	assign syncIn = {ck, tempRate, cmdPins};

	sync2 #(
		.W(SYNC_W)
	) u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.din(syncIn),
		.dout(syncOut)
	);

	assign ckS = syncOut[SYNC_W-1];
	assign tempS = syncOut[SYNC_W-2 -: 2];
	assign cmd = syncOut[$bits(cmd_s)-1:0];

	// cas latency from its code, additive latency from the mode
	function automatic logic [5:0] readLatency(input state_s s);
		logic [5:0] cl;
		logic [1:0] al;
		cl = 6'h00;
		al = 2'b00;
		cl = CL_BASE + 6'({s.mr[MR0_IDX][6:4], s.mr[MR0_IDX][2]});
		al = s.mr[MR1_IDX][MR1_AL_LSB +: 2];
		case (al)
			2'b01: readLatency = cl + cl - 6'h01;
			2'b10: readLatency = cl + cl - 6'h02;
			default: readLatency = cl;
		endcase
	endfunction

	// contents of one readout location of the chosen page
	function automatic logic [7:0] locByte(input state_s s,
		input logic [1:0] pg, input logic [1:0] loc);
		locByte = 8'h00;
		case (pg)
			2'b00: locByte = s.page0[loc];
			2'b01: begin
				if (loc == 2'b11) begin
					locByte = {5'h00, s.mr[MR5_IDX][MR5_CAPL_LSB +: 3]}; // RULE4
				end
			end
			2'b10: begin
				case (loc)
					2'b00: locByte = {2'b00, s.mr[MR2_IDX][11], s.temp,
						s.mr[MR2_IDX][12], s.mr[MR2_IDX][10:9]};
					2'b01: locByte = {s.mr[MR6_IDX][6:0], s.mr[MR3_IDX][3]};
					2'b10: locByte = {s.mr[MR0_IDX][6:4], s.mr[MR0_IDX][2],
						1'b0, s.mr[MR2_IDX][5:3]};
					default: locByte = {s.mr[MR1_IDX][10:8],
						s.mr[MR5_IDX][8:6], s.mr[MR1_IDX][2:1]};
				endcase
			end
			default: locByte = 8'h00;
		endcase
	endfunction

	assign ckRise = ckS & ~q.ckPrev;
	assign ckFall = ~ckS & q.ckPrev;
	assign isMrs = ~cmd.csN & cmd.actN & ~cmd.rasN & ~cmd.casN & ~cmd.weN;
	assign isRd = ~cmd.csN & cmd.actN & cmd.rasN & ~cmd.casN & cmd.weN;
	assign isWr = ~cmd.csN & cmd.actN & cmd.rasN & ~cmd.casN & ~cmd.weN;
	assign mprOn = q.mr[MR3_IDX][MR3_MPR_EN_BIT];
	assign tempEn = q.mr[MR3_IDX][MR3_TEMP_EN_BIT];
	assign mrSel = {cmd.bg, cmd.ba};

	// fixed burst from mode 0 only; the chop pin is not consulted
	assign bl8 = q.mr[MR0_IDX][MR0_BL_LSB +: 2] != 2'b10; // RULE5
	assign refused = bl8 & cmd.addr[A_START_BIT]; // RULE15
	assign rdGo = ckRise & isRd & mprOn & (q.phase == PH_IDLE) & ~refused;
	assign wrHit = ckRise & isWr & mprOn &
		(q.mr[MR3_IDX][MR3_PAGE_LSB +: 2] == 2'b00);
	assign rlLoad = readLatency(q);
	assign preLen = q.mr[MR4_IDX][MR4_PRE_BIT] ? 2'b10 : 2'b01;
	// page from mode 3, location from bank bits; bg and A10 not used
	assign locData = locByte(q, q.mr[MR3_IDX][MR3_PAGE_LSB +: 2],
		cmd.ba); // RULE12 RULE13 RULE17

	always_comb begin
		d = q;
		d.ckPrev = ckS;
		d.dbiN = 1'b1; // RULE6

		if (ckRise & isMrs & (mrSel < 3'(MR_COUNT))) begin
			d.mr[mrSel] = cmd.addr;
			// turning status on refreshes the bits at once
			if (mrSel == 3'(MR3_IDX) && cmd.addr[MR3_TEMP_EN_BIT] && !tempEn) begin
				d.tempCnt = '0; // RULE1
			end
		end

		if (wrHit) begin
			d.page0[cmd.ba] = cmd.addr[7:0]; // RULE8
		end

		if (tempEn) begin
			if (q.tempCnt == '0) begin
				d.temp = tempS; // RULE1 RULE3
				d.tempCnt = TEMP_RELOAD;
			end else begin
				d.tempCnt = q.tempCnt - 1'b1;
			end
		end // RULE2

		case (q.phase)
			PH_IDLE: begin
				if (rdGo) begin
					d.phase = PH_WAIT;
					d.cnt = rlLoad - 6'(preLen); // RULE18
					d.beatsLeft = bl8 ? BEATS_BL8 : BEATS_BC4;
					// start at beat 4: low nibble goes first
					d.dataByte = cmd.addr[A_START_BIT] ?
						{locData[3:0], 4'h0} : locData; // RULE16
					// only parallel differs; staggered falls back to serial
					d.par = fmt_e'(q.mr[MR3_IDX][MR3_FMT_LSB +: 2]) ==
						FMT_PARALLEL; // RULE11
				end
			end
			PH_WAIT: begin
				if (ckRise) begin
					if (q.cnt == 6'h01) begin
						d.phase = PH_PRE;
						d.preCnt = preLen;
						d.dqsOe = 1'b1; // RULE21
						d.dqs = 1'b0;
					end else begin
						d.cnt = q.cnt - 6'h01;
					end
				end
			end
			PH_PRE: begin
				if (ckRise) begin
					if (q.preCnt == 2'b01) begin
						d.phase = PH_DATA;
					end else begin
						d.preCnt = q.preCnt - 2'b01;
					end
				end
			end
			PH_DATA: begin
				if (ckRise | ckFall) begin
					if (q.beatsLeft == 4'h0) begin
						d.phase = PH_IDLE;
						d.dqOe = 1'b0;
						d.dqsOe = 1'b0;
						d.dqs = 1'b0;
						d.dq = 8'h00;
					end
				end
			end
			default: d.phase = PH_IDLE;
		endcase

		// beat output: the entering edge and each edge after it
		if ((q.phase == PH_PRE && ckRise && q.preCnt == 2'b01) ||
			(q.phase == PH_DATA && (ckRise | ckFall) &&
			q.beatsLeft != 4'h0)) begin
			d.dqOe = 1'b1;
			d.dqs = ckRise; // RULE21
			d.dq = q.par ? q.dataByte : {8{q.dataByte[7]}}; // RULE22
			d.dataByte = {q.dataByte[6:0], 1'b0}; // RULE15
			d.beatsLeft = q.beatsLeft - 4'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
			q.mr <= {MR_COUNT{MR_RESET}};
			q.page0 <= {PAGE0_LOC3_RESET, PAGE0_LOC2_RESET,
				PAGE0_LOC1_RESET, PAGE0_LOC0_RESET}; // RULE8
			q.phase <= PH_IDLE;
			q.dbiN <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign dqOut = q.dq;
	assign dqOe = q.dqOe;
	assign dqsOut = q.dqs;
	assign dqsOe = q.dqsOe;
	assign dbiNOut = q.dbiN;
	assign readoutActive = q.mr[MR3_IDX][MR3_MPR_EN_BIT];

	a_dbi_never_low: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
		q.dqOe |-> q.dbiN)
		else $error("readout data inverted");

	a_strobe_with_data: assert property ( // RULE21
		@(posedge clk) disable iff (!rst_b)
		q.dqOe |-> q.dqsOe && q.phase == PH_DATA)
		else $error("data driven without strobe");

	a_serial_lanes_same: assert property ( // RULE22
		@(posedge clk) disable iff (!rst_b)
		(q.dqOe && !q.par) |-> (q.dq == 8'h00 || q.dq == 8'hFF))
		else $error("serial lanes differ");

	a_parity_mirror: assert property (@(posedge clk) disable iff (!rst_b) // RULE4
		(ckRise && isMrs && mrSel == 3'(MR5_IDX)) |=>
		locByte(q, 2'b01, 2'b11) == {5'h00, $past(cmd.addr[2:0])})
		else $error("parity latency not mirrored");

	a_temp_frozen: assert property (@(posedge clk) disable iff (!rst_b) // RULE2
		(!tempEn && $past(!tempEn)) |-> $stable(q.temp))
		else $error("temperature bits moved while disabled");

	a_temp_age_bound: assert property ( // RULE1
		@(posedge clk) disable iff (!rst_b)
		tempEn |-> q.tempCnt < TEMP_CNT_W'(TEMP_UPDATE))
		else $error("temperature update interval exceeded");

	a_bl8_refused: assert property (@(posedge clk) disable iff (!rst_b) // RULE15
		(ckRise && isRd && q.phase == PH_IDLE && refused) |=> q.phase == PH_IDLE)
		else $error("forbidden BL8 start accepted");

	a_read_latency: assert property (@(posedge clk) disable iff (!rst_b) // RULE18
		rdGo |=> q.phase == PH_WAIT && q.cnt == $past(rlLoad) - 6'($past(preLen)))
		else $error("read latency load wrong");

	a_page0_keeps: assert property (@(posedge clk) disable iff (!rst_b) // RULE8
		$changed(q.page0) |-> $past(wrHit))
		else $error("page 0 changed without write");

	a_preamble_low: assert property (@(posedge clk) disable iff (!rst_b) // RULE21
		(q.phase == PH_WAIT && $past(q.phase) == PH_WAIT) ##1 q.phase == PH_PRE
		|-> q.dqsOe && !q.dqs && !q.dqOe)
		else $error("preamble not held low");

	a_idle_quiet: assert property ( // RULE21
		@(posedge clk) disable iff (!rst_b)
		q.phase == PH_IDLE |-> !q.dqOe && !q.dqsOe)
		else $error("pins driven while idle");

	a_bc4_beats: assert property ( // RULE5
		@(posedge clk) disable iff (!rst_b)
		(rdGo && q.mr[MR0_IDX][MR0_BL_LSB +: 2] == 2'b10) |=>
		q.beatsLeft == BEATS_BC4)
		else $error("fixed BC4 burst not four beats");

	a_start_upper: assert property ( // RULE16
		@(posedge clk) disable iff (!rst_b)
		(rdGo && cmd.addr[A_START_BIT]) |=>
		q.dataByte[7:4] == $past(locData[3:0]))
		else $error("BC4 upper start sends wrong half");

	a_read_when_off: assert property ( // RULE13
		@(posedge clk) disable iff (!rst_b)
		(ckRise && isRd && !mprOn && q.phase == PH_IDLE) |=>
		q.phase == PH_IDLE)
		else $error("read accepted outside readout mode");

	a_temp_load: assert property ( // RULE1
		@(posedge clk) disable iff (!rst_b)
		(tempEn && q.tempCnt == '0) |=> q.temp == $past(tempS))
		else $error("temperature status not refreshed");

	a_write_lands: assert property ( // RULE8
		@(posedge clk) disable iff (!rst_b)
		wrHit |=> q.page0[$past(cmd.ba)] == $past(cmd.addr[7:0]))
		else $error("page 0 write lost");

	a_fmt_serial: assert property ( // RULE11
		@(posedge clk) disable iff (!rst_b)
		(rdGo && q.mr[MR3_IDX][MR3_FMT_LSB +: 2] != 2'b01) |=> !q.par)
		else $error("non-parallel format sent parallel");

	a_burst_end: assert property ( // RULE21
		@(posedge clk) disable iff (!rst_b)
		(q.phase == PH_DATA && q.beatsLeft == 4'h0 && (ckRise || ckFall))
		|=> !q.dqOe && !q.dqsOe && q.phase == PH_IDLE)
		else $error("pins still driven after last beat");

endmodule

// ### tb/mpr_ctrl_model.sv
// controller model: makes the memory clock, issues commands, collects bursts
`timescale 1ns/1ps
module mpr_ctrl_model
	import mpr_pkg::*;
(
	input wire logic clk,
	output logic ck,
	output cmd_s cmdPins,
	input wire logic [7:0] dqOut,
	input wire logic dqOe,
	input wire logic dqsOut,
	input wire logic dqsOe
);
	logic [2:0] div;
	logic prevDqs;
	logic prevOe;
	int riseCnt;
	int cmdRise;
	int firstRise;
	int preCnt;
	int nBeats;
	logic [7:0] beats[8];
	initial begin
		ck = 1'b0;
		div = 3'h0;
		riseCnt = 0;
		nBeats = 0;
		preCnt = 0;
		prevOe = 1'b0;
		prevDqs = 1'b0;
		cmdPins = '1;
	end
	// the memory clock runs free, as on a real board
	always @(posedge clk) begin
		div <= div + 3'h1;
		if (div == 3'h7) begin
			ck <= ~ck;
			if (ck === 1'b0)
				riseCnt <= riseCnt + 1;
		end
		prevDqs <= dqsOut;
		prevOe <= dqOe;
		if (dqsOe === 1'b1 && dqOe === 1'b0)
			preCnt <= preCnt + 1;
		// a beat is a change of strobe while data is driven
		if (dqOe === 1'b1 && (prevOe !== 1'b1 || dqsOut !== prevDqs)) begin
			if (prevOe !== 1'b1)
				firstRise <= riseCnt;
			if (nBeats < 8)
				beats[nBeats] <= dqOut;
			nBeats <= nBeats + 1;
		end
	end
	// one command per ck period, launched on the falling edge
	task automatic issue(input cmd_s c);
		@(negedge ck);
		cmdPins <= c;
		cmdRise <= riseCnt + 1;
		nBeats <= 0;
		preCnt <= 0;
		@(negedge ck);
		// deselect; the other pins flip so stale values are never reused
		cmdPins <= ~c;
	endtask
endmodule

// ### tb/mpr_readout_tb_top.sv
// testbench: readout mode entry, reads in pages 0 to 2 and in serial, parallel and staggered format, exit
`timescale 1ns/1ps
module mpr_readout_tb_top
	import mpr_pkg::*;
;
	localparam logic [2:0] OP_MRS = 3'b000;
	localparam logic [2:0] OP_RD = 3'b101;
	localparam logic [2:0] OP_WR = 3'b100;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [1:0] tempRate = 2'b00;
	logic bcPin = 1'b0;
	logic ck, dqOe, dqsOut, dqsOe, dbiNOut, readoutActive;
	cmd_s cmdPins;
	logic [7:0] dqOut;
	int fails = 0;
	int n_tests = 0;
	mpr_readout #(.TEMP_UPDATE(50)) mpr_readout_inst (.clk(clk),
		.rst_b(rst_b), .ck(ck), .cmdPins(cmdPins), .tempRate(tempRate),
		.dqOut(dqOut), .dqOe(dqOe), .dqsOut(dqsOut), .dqsOe(dqsOe),
		.dbiNOut(dbiNOut), .readoutActive(readoutActive));
	mpr_ctrl_model mpr_ctrl_model_inst (.clk(clk), .ck(ck),
		.cmdPins(cmdPins), .dqOut(dqOut), .dqOe(dqOe), .dqsOut(dqsOut),
		.dqsOe(dqsOe));
	always #5 clk = ~clk;
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("FAIL at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic send(input logic [2:0] op, input logic [2:0] idx,
		input logic [13:0] a);
		cmd_s c;
		c = '0;
		c.actN = 1'b1;
		{c.rasN, c.casN, c.weN} = op;
		{c.bg, c.ba} = idx;
		c.addr = a;
		mpr_ctrl_model_inst.issue(c);
	endtask
	// A10 and the group bit are set on purpose: they must not matter
	task automatic readLoc(input logic [1:0] loc, input logic a2, input int n);
		send(OP_RD, {1'b1, loc},
			{1'b0, bcPin, 1'b0, 1'b1, 7'h00, a2, 2'b00});
		for (int i = 0; i < 700; i++) begin
			@(posedge clk);
			if (n > 0 && mpr_ctrl_model_inst.nBeats == n && dqOe === 1'b0)
				break;
		end
		check(32'(mpr_ctrl_model_inst.nBeats), 32'(n));
	endtask
	task automatic expSerial(input logic [7:0] b, input int n, input int top);
		for (int k = 0; k < n; k++)
			check(32'(mpr_ctrl_model_inst.beats[k]), 32'({8{b[top-k]}}));
	endtask
	task automatic expTiming(input int rl, input int p);
		check(32'(mpr_ctrl_model_inst.firstRise - mpr_ctrl_model_inst.cmdRise),
			32'(rl));
		check(32'((mpr_ctrl_model_inst.preCnt + 4) / 16), 32'(p));
	endtask
	task automatic s_page0();
		logic [7:0] dflt[4];
		dflt = '{PAGE0_LOC0_RESET, PAGE0_LOC1_RESET, PAGE0_LOC2_RESET,
			PAGE0_LOC3_RESET};
		send(OP_MRS, 3'd3, 14'h0004);
		check(32'(readoutActive), 32'h1);
		for (int l = 0; l < 4; l++) begin
			readLoc(2'(l), 1'b0, 8);
			expSerial(dflt[l], 8, 7);
		end
		expTiming(9, 1);
		send(OP_WR, 3'd1, 14'h00A5);
		readLoc(2'd1, 1'b0, 8);
		expSerial(8'hA5, 8, 7);
	endtask
	task automatic s_latency();
		send(OP_MRS, 3'd1, 14'h0008);
		send(OP_MRS, 3'd4, 14'h0800);
		readLoc(2'd2, 1'b0, 8);
		expTiming(17, 2);
		send(OP_MRS, 3'd1, 14'h0000);
		send(OP_MRS, 3'd4, 14'h0000);
	endtask
	task automatic s_burst();
		send(OP_MRS, 3'd0, 14'h0002);
		readLoc(2'd0, 1'b0, 4);
		expSerial(PAGE0_LOC0_RESET, 4, 7);
		readLoc(2'd0, 1'b1, 4);
		expSerial(PAGE0_LOC0_RESET, 4, 3);
		send(OP_MRS, 3'd0, 14'h0000);
		readLoc(2'd0, 1'b1, 0);
		// on-the-fly code: the chop pin is held high, burst stays eight
		send(OP_MRS, 3'd0, 14'h0001);
		bcPin = 1'b1;
		readLoc(2'd2, 1'b0, 8);
		expSerial(PAGE0_LOC2_RESET, 8, 7);
		bcPin = 1'b0;
		send(OP_MRS, 3'd0, 14'h0000);
	endtask
	task automatic s_pages();
		send(OP_MRS, 3'd5, 14'h1005);
		send(OP_MRS, 3'd3, 14'h0005);
		readLoc(2'd3, 1'b0, 8);
		expSerial(8'h05, 8, 7);
		check(32'(dbiNOut), 32'h1);
		tempRate <= 2'b10;
		send(OP_MRS, 3'd3, 14'h0026);
		repeat (60) @(posedge clk);
		readLoc(2'd0, 1'b0, 8);
		expSerial(8'h10, 8, 7);
		send(OP_MRS, 3'd3, 14'h0006);
		tempRate <= 2'b01;
		repeat (120) @(posedge clk);
		readLoc(2'd0, 1'b0, 8);
		expSerial(8'h10, 8, 7);
		send(OP_MRS, 3'd3, 14'h0026);
		repeat (60) @(posedge clk);
		readLoc(2'd0, 1'b0, 8);
		expSerial(8'h08, 8, 7);
		// no new enable edge here: only the periodic refresh can move it
		tempRate <= 2'b00;
		repeat (120) @(posedge clk);
		readLoc(2'd0, 1'b0, 8);
		expSerial(8'h00, 8, 7);
	endtask
	task automatic s_format();
		send(OP_MRS, 3'd3, 14'h0804);
		readLoc(2'd1, 1'b0, 8);
		for (int k = 0; k < 8; k++)
			check(32'(mpr_ctrl_model_inst.beats[k]), 32'(8'(8'hA5 << k)));
		send(OP_MRS, 3'd3, 14'h1004);
		readLoc(2'd1, 1'b0, 8);
		expSerial(8'hA5, 8, 7);
		send(OP_MRS, 3'd3, 14'h0000);
		check(32'(readoutActive), 32'h0);
		readLoc(2'd0, 1'b0, 0);
	endtask
	task automatic summarize();
		$display("checks %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clk);
		fails++;
		summarize();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		check(32'({dqOe, dqsOe, dbiNOut, readoutActive}), 32'h2);
		s_page0();
		s_latency();
		s_burst();
		s_pages();
		s_format();
		summarize();
	end
endmodule
